// *** rtl/bcs_pkg.sv ***
// Purpose: shared constants and types of the branch, call and skip unit
// Assumes: 32-bit apb register words, one aligned word per register
// Notes: offsets are byte addresses on paddr
package bcs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPWORD = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_ZPTR = 8'h0C;
  localparam logic [7:0] OFF_EXT_HIGH = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_OPERANDS = 8'h18;
  localparam logic [7:0] OFF_SP = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PC22_BIT = 1;
  localparam int OPW_CODE_LSB = 0;
  localparam int OPW_BSEL_LSB = 8;
  localparam int OPW_K_LSB = 16;
  localparam int OPW_TWO_BIT = 24;
  localparam int OPND_RD_LSB = 0;
  localparam int OPND_RR_LSB = 8;
  localparam int OPND_IO_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB = 4;

  // processor flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [21:0] PC_RST = 22'h00_0000;
  localparam logic [15:0] SP_RST = 16'h7FFF;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [1:0] BYTES_SHORT = 2'h2;
  localparam logic [1:0] BYTES_LONG = 2'h3;

  // operation codes, numbered in this order from zero
  typedef enum logic [4:0] {
    op_indirect_call,
    op_extended_indirect_call,
    op_compare_skip_equal,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_carry_set,
    op_branch_carry_clear,
    op_branch_same_or_higher,
    op_branch_lower,
    op_branch_minus,
    op_branch_plus,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_halfcarry_set,
    op_branch_halfcarry_clear,
    op_branch_transfer_bit_set,
    op_branch_transfer_bit_clear,
    op_branch_overflow_set,
    op_branch_overflow_clear,
    op_branch_irq_enabled,
    op_branch_irq_disabled
  } op_t;

endpackage

// *** rtl/branch_call_skip_control.sv ***
// Purpose: executes calls, skips and conditional branches on a program counter
// Assumes: apb master, one pclk domain, stack write port to data memory
// Notes: all register writes are ignored while busy; status is never writable
//
// Function
// - indirect call loads pc 15:0 from z, zeroes 21:16, 2 or 3 cycles
// - extended indirect call takes pc 21:16 from extended register, 3 cycles
// - compare-skip-equal skips next instruction when registers match, 1 to 3 cycles
// - register bit clear skip skips when bit is zero, no flag change
// - register bit set skip skips when bit is one, 1 to 3 cycles
// - io bit clear skip skips when io bit is zero, 2 to 4 cycles
// - io bit set skip skips when io bit is one, 2 to 4 cycles
// - flag-set branches go to pc plus offset plus one, 1 or 2 cycles
// - flag-clear branches go to pc plus offset plus one when flag is zero
// - same-or-higher branch taken when carry is zero
// - signed greater-or-equal taken when negative xor overflow is zero
// - signed less-than taken when negative xor overflow is one
// - half-carry branches test the half-carry flag, same target and timing
// - transfer-bit branches test the transfer bit, 1 or 2 cycles
// - overflow branches test the overflow flag, 1 or 2 cycles
// - irq-enabled branch taken when global interrupt enable is one
// - irq-disabled branch taken when enable is zero; no flag is changed
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module branch_call_skip_control import bcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic stack_we,
  output logic [15:0] stack_addr,
  output logic [7:0] stack_wdata,
  output logic exec_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic taken;
    logic pc22;
    logic [3:0] cnt;
    logic [3:0] cycles;
    logic [1:0] push_idx;
    logic [1:0] nbytes;
    logic [21:0] pc;
    logic [21:0] tgt;
    logic [21:0] ret;
    logic [15:0] z;
    logic [5:0] ext;
    logic [7:0] flags;
    logic [31:0] opw;
    logic [23:0] opnd;
    logic [15:0] sp;
    logic st_we;
    logic [15:0] st_addr;
    logic [7:0] st_data;
    logic [31:0] rdata;
    logic err;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  op_t op;
  logic cond;
  logic setup;
  logic wr_go;
  logic start;
  logic is_call;
  logic is_skip;
  logic is_io;
  logic two;
  logic [21:0] sext_k;
  logic [21:0] skip_len;

  assign op = op_t'(st_r.opw[OPW_CODE_LSB +: 5]);
  assign two = st_r.opw[OPW_TWO_BIT];
  assign sext_k = {{15{st_r.opw[OPW_K_LSB + 6]}}, st_r.opw[OPW_K_LSB +: 7]};
  assign skip_len = two ? 22'h00_0003 : 22'h00_0002;
  assign is_call = (op == op_indirect_call) || (op == op_extended_indirect_call);
  assign is_io = (op == op_skip_io_bit_clear) || (op == op_skip_io_bit_set);
  assign is_skip = (op == op_compare_skip_equal) || (op == op_skip_reg_bit_clear) ||
                   (op == op_skip_reg_bit_set) || is_io;

  flag_cond u_cond (
    .op(op),
    .flags(st_r.flags),
    .bsel(st_r.opw[OPW_BSEL_LSB +: 3]),
    .rd(st_r.opnd[OPND_RD_LSB +: 8]),
    .rr(st_r.opnd[OPND_RR_LSB +: 8]),
    .io_val(st_r.opnd[OPND_IO_LSB +: 8]),
    .cond(cond)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pwrite & ~st_r.busy;
  assign start = wr_go & (paddr == OFF_CTRL) & pwdata[CTRL_START_BIT];
  assign pready = 1'b1;
  assign pslverr = psel & penable & st_r.err;
  assign prdata = st_r.rdata;
  assign stack_we = st_r.st_we;
  assign stack_addr = st_r.st_addr;
  assign stack_wdata = st_r.st_data;
  assign exec_busy = st_r.busy;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.err = 1'b0;
      case (paddr)
        OFF_CTRL: st_nxt.rdata = {30'h0000_0000, st_r.pc22, 1'b0};
        OFF_OPWORD: st_nxt.rdata = st_r.opw;
        OFF_PC: st_nxt.rdata = {10'h000, st_r.pc};
        OFF_ZPTR: st_nxt.rdata = {16'h0000, st_r.z};
        OFF_EXT_HIGH: st_nxt.rdata = {26'h000_0000, st_r.ext};
        OFF_FLAGS: st_nxt.rdata = {24'h00_0000, st_r.flags};
        OFF_OPERANDS: st_nxt.rdata = {8'h00, st_r.opnd};
        OFF_SP: st_nxt.rdata = {16'h0000, st_r.sp};
        OFF_STATUS: st_nxt.rdata = {24'h00_0000, st_r.cycles, 2'b00, st_r.taken, st_r.busy};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.err = 1'b1;
        end
      endcase
    end
    // flags are only ever written from the bus, never by execution
    if (wr_go) begin
      case (paddr)
        OFF_CTRL: st_nxt.pc22 = pwdata[CTRL_PC22_BIT];
        OFF_OPWORD: st_nxt.opw = pwdata;
        OFF_PC: st_nxt.pc = pwdata[21:0];
        OFF_ZPTR: st_nxt.z = pwdata[15:0];
        OFF_EXT_HIGH: st_nxt.ext = pwdata[5:0];
        OFF_FLAGS: st_nxt.flags = pwdata[7:0];
        OFF_OPERANDS: st_nxt.opnd = pwdata[23:0];
        OFF_SP: st_nxt.sp = pwdata[15:0];
        default: st_nxt.err = st_r.err;
      endcase
    end
    st_nxt.st_we = 1'b0;
    if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.taken = cond;
      st_nxt.push_idx = 2'h0;
      st_nxt.nbytes = 2'h0;
      st_nxt.ret = st_r.pc + 22'h00_0001;
      if (is_call) begin
        // longer counter needs a third stacked byte, and one more cycle on the plain indirect call
        st_nxt.nbytes = st_r.pc22 ? BYTES_LONG : BYTES_SHORT;
        if (op == op_extended_indirect_call) begin
          st_nxt.tgt = {st_r.ext, st_r.z};
          st_nxt.cycles = CYC_THREE;
        end else begin
          st_nxt.tgt = {6'h00, st_r.z};
          st_nxt.cycles = st_r.pc22 ? CYC_THREE : CYC_TWO;
        end
      end else if (is_skip) begin
        st_nxt.tgt = st_r.pc + (cond ? skip_len : 22'h00_0001);
        st_nxt.cycles = (cond ? skip_len[3:0] : CYC_ONE) + {3'b000, is_io};
      end else begin
        st_nxt.tgt = cond ? (st_r.pc + sext_k + 22'h00_0001) : (st_r.pc + 22'h00_0001);
        st_nxt.cycles = cond ? CYC_TWO : CYC_ONE;
      end
      st_nxt.cnt = st_nxt.cycles;
    end else if (st_r.busy) begin
      // push one return address byte per cycle, low byte first
      if (st_r.push_idx < st_r.nbytes) begin
        st_nxt.st_we = 1'b1;
        st_nxt.st_addr = st_r.sp;
        st_nxt.st_data = 8'(st_r.ret >> {st_r.push_idx, 3'b000});
        st_nxt.sp = st_r.sp - 16'h0001;
        st_nxt.push_idx = st_r.push_idx + 2'h1;
      end
      if (st_r.cnt == CYC_ONE) begin
        st_nxt.busy = 1'b0;
        st_nxt.pc = st_r.tgt;
      end else begin
        st_nxt.cnt = st_r.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.pc <= PC_RST;
      st_r.sp <= SP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  op_t h_op;
  logic [21:0] h_pc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_op <= op_indirect_call;
      h_pc <= PC_RST;
    end else if (start) begin
      h_op <= op;
      h_pc <= st_r.pc;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence busy_one;
    st_r.busy ##1 !st_r.busy;
  endsequence
  sequence busy_two;
    st_r.busy [*2] ##1 !st_r.busy;
  endsequence
  sequence busy_three;
    st_r.busy [*3] ##1 !st_r.busy;
  endsequence

  a_indirect_call_short_time: assert property (
    (start && op == op_indirect_call && !st_r.pc22) |=> busy_two)
    else $error("indirect call with 16-bit counter not two cycles");
  a_indirect_call_zero_high: assert property (
    (st_r.busy && st_r.cnt == CYC_ONE && h_op == op_indirect_call)
      |=> (st_r.pc[21:16] == 6'h00 && st_r.pc[15:0] == st_r.z))
    else $error("indirect call target wrong");
  a_extended_indirect_call_three_cycles: assert property (
    (start && op == op_extended_indirect_call) |=> busy_three ##0 (st_r.pc[21:16] == st_r.ext))
    else $error("extended indirect call timing or target wrong");
  a_compare_skip_equal_skip_one: assert property (
    (start && op == op_compare_skip_equal && cond && !two)
      |=> busy_two ##0 (st_r.pc == 22'(h_pc + 22'h00_0002)))
    else $error("compare skip did not skip one word");
  a_skip_reg_bit_clear_no_skip: assert property (
    (start && op == op_skip_reg_bit_clear && !cond) |=> busy_one ##0 (st_r.pc == 22'(h_pc + 22'h00_0001)))
    else $error("register bit clear skip wrong when bit set");
  a_skip_io_bit_set_long_skip: assert property (
    (start && op == op_skip_io_bit_set && cond && two) |=> st_r.busy [*4] ##1 !st_r.busy)
    else $error("io bit set skip over two words not four cycles");
  a_branch_taken_pc: assert property (
    (start && op == op_branch_flag_set && cond)
      |=> busy_two ##0 (st_r.pc == 22'(h_pc + sext_k + 22'h00_0001)))
    else $error("taken branch target or timing wrong");
  a_signed_ge_cond: assert property (
    (start && op == op_branch_signed_ge) |-> (cond == (st_r.flags[FLAG_N] == st_r.flags[FLAG_V])))
    else $error("signed greater-or-equal condition wrong");
  a_flags_untouched: assert property (
    st_r.busy |=> $stable(st_r.flags))
    else $error("flags changed during execution");
  a_call_pushes_bytes: assert property (
    (start && is_call && st_r.pc22) |=> ##1 st_r.st_we [*3] ##1 !st_r.st_we)
    else $error("call did not push three return bytes");

endmodule // branch_call_skip_control

// *** rtl/flag_cond.sv ***
// Purpose: decides whether a skip or branch condition holds
// Assumes: inputs come from registers on the same clock
// Notes: purely combinational
`timescale 1ns/100ps
module flag_cond import bcs_pkg::*; (
  input wire op_t op,
  input wire logic [7:0] flags,
  input wire logic [2:0] bsel,
  input wire logic [7:0] rd,
  input wire logic [7:0] rr,
  input wire logic [7:0] io_val,
  output logic cond
);

  // ----------------------------------------------------------------
  // condition table
  // ----------------------------------------------------------------
  always_comb begin
    cond = 1'b0;
    case (op)
      op_indirect_call, op_extended_indirect_call: cond = 1'b1;
      op_compare_skip_equal: cond = (rd == rr);
      op_skip_reg_bit_clear: cond = ~rr[bsel];
      op_skip_reg_bit_set: cond = rr[bsel];
      op_skip_io_bit_clear: cond = ~io_val[bsel];
      op_skip_io_bit_set: cond = io_val[bsel];
      op_branch_flag_set: cond = flags[bsel];
      op_branch_flag_clear: cond = ~flags[bsel];
      op_branch_equal: cond = flags[FLAG_Z];
      op_branch_not_equal: cond = ~flags[FLAG_Z];
      op_branch_carry_set: cond = flags[FLAG_C];
      op_branch_carry_clear: cond = ~flags[FLAG_C];
      op_branch_same_or_higher: cond = ~flags[FLAG_C];
      op_branch_lower: cond = flags[FLAG_C];
      op_branch_minus: cond = flags[FLAG_N];
      op_branch_plus: cond = ~flags[FLAG_N];
      op_branch_signed_ge: cond = ~(flags[FLAG_N] ^ flags[FLAG_V]);
      op_branch_signed_lt: cond = flags[FLAG_N] ^ flags[FLAG_V];
      op_branch_halfcarry_set: cond = flags[FLAG_H];
      op_branch_halfcarry_clear: cond = ~flags[FLAG_H];
      op_branch_transfer_bit_set: cond = flags[FLAG_T];
      op_branch_transfer_bit_clear: cond = ~flags[FLAG_T];
      op_branch_overflow_set: cond = flags[FLAG_V];
      op_branch_overflow_clear: cond = ~flags[FLAG_V];
      op_branch_irq_enabled: cond = flags[FLAG_I];
      op_branch_irq_disabled: cond = ~flags[FLAG_I];
      default: cond = 1'b0;
    endcase
  end

endmodule // flag_cond

// *** sim/stack_model.sv ***
// Purpose: data-memory stack behind the push port
// Assumes: one byte per stack_we pulse, pclk domain
// Notes: write-only port, so there is no read bus to release
`timescale 1ns/100ps
module stack_model (
  input wire logic pclk,
  input wire logic stack_we,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata
);
  logic [7:0] mem [0:65535];
  int pushes = 0;

  // ----------------------------
  // byte capture
  // ----------------------------
  // counts pushes too, so stray pulses show up as extra bytes
  always @(posedge pclk) begin
    if (stack_we === 1'b1) begin
      mem[stack_addr] <= stack_wdata;
      pushes <= pushes + 1;
    end
  end
endmodule // stack_model

// *** sim/test_branch_call_skip_control.sv ***
// Purpose: self-checking bench of the branch, call and skip unit
// Assumes: zero-wait apb slave, 25 MHz pclk
// Notes: expected targets and counts are worked out here
`timescale 1ns/100ps
module test_branch_call_skip_control import bcs_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stack_we, exec_busy, err;
  logic [7:0] paddr, stack_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] stack_addr;
  int fails = 0, check_count = 0, busy_cnt = 0;
  // flag index per opcode, 8 meaning negative xor overflow
  localparam int IDX [27] = '{0,0,0,0,0,0,0,0,0,1,1,0,0,0,0,2,2,8,8,5,5,6,6,3,3,7,7};
  localparam bit POL [27] = '{0,0,0,0,0,0,0,0,0,1,0,1,0,0,1,1,0,0,1,1,0,1,0,1,0,1,0};

  // ----------------------------
  // clock, design, partner
  // ----------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  branch_call_skip_control u_branch_call_skip_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stack_we(stack_we),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata), .exec_busy(exec_busy));

  stack_model u_stack_model (.pclk(pclk), .stack_we(stack_we), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata));

  always @(posedge pclk) begin
    if (exec_busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // ----------------------------
  // shared tasks
  // ----------------------------
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      $display("[FAIL] %0t pready never came", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ow(input logic [4:0] op, input logic [2:0] b,
      input logic [6:0] k, input logic two);
    return {7'h00, two, 1'b0, k, 5'h00, b, 3'h0, op};
  endfunction

  function automatic logic cond(input int op, input logic [7:0] f, input logic [2:0] b);
    logic [8:0] v;
    v = {f[2] ^ f[3], f};
    if (op < 9) begin
      return f[b] ~^ (op == 7);
    end
    return v[IDX[op]] == POL[op];
  endfunction

  // start one operation, wait for busy to drop, judge pc and duration
  task automatic exec(input logic [31:0] opw, input logic [21:0] pc0, input logic [1:0] ctl,
      input logic [21:0] exp_pc, input logic [3:0] exp_cyc);
    int n;
    apb(1'b1, OFF_PC, {10'h000, pc0});
    apb(1'b1, OFF_OPWORD, opw);
    busy_cnt = 0;
    apb(1'b1, OFF_CTRL, {30'h0000_0000, ctl});
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (exec_busy !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("[FAIL] %0t busy stuck", $time);
      end_sim();
    end
    @(posedge pclk);
    apb(1'b0, OFF_PC, 32'h0000_0000);
    chk(rd, {10'h000, exp_pc}, "pc");
    chk(32'(busy_cnt), {28'h000_0000, exp_cyc}, "cycles");
    // taken unless the target is the plain next word
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd, {24'h00_0000, exp_cyc, 2'b00, exp_pc != (pc0 + 22'h00_0001), 1'b0}, "status");
  endtask

  task automatic sk(input logic [4:0] op, input logic [2:0] b, input logic two,
      input logic [21:0] exp_pc, input logic [3:0] cyc);
    exec(ow(op, b, 7'h00, two), 22'h00_0010, 2'b01, exp_pc, cyc);
  endtask

  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic t_reset();
    apb(1'b0, OFF_PC, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "pc reset");
    apb(1'b0, OFF_SP, 32'h0000_0000);
    chk(rd, 32'h0000_7FFF, "sp reset");
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
  endtask

  task automatic t_calls();
    apb(1'b1, OFF_ZPTR, 32'h0000_1234);
    apb(1'b1, OFF_EXT_HIGH, 32'h0000_002A);
    exec(ow(op_indirect_call, 3'h0, 7'h00, 1'b0), 22'h3F_0010, 2'b01, 22'h00_1234, 4'h2);
    chk({16'h0000, u_stack_model.mem[16'h7FFF], u_stack_model.mem[16'h7FFE]},
      32'h0000_1100, "push16");
    apb(1'b0, OFF_SP, 32'h0000_0000);
    chk(rd, 32'h0000_7FFD, "sp");
    // counter width is sampled at start, so it must be set beforehand
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    exec(ow(op_extended_indirect_call, 3'h0, 7'h00, 1'b0), 22'h12_3456, 2'b11,
      22'h2A_1234, 4'h3);
    chk({8'h00, u_stack_model.mem[16'h7FFD], u_stack_model.mem[16'h7FFC],
      u_stack_model.mem[16'h7FFB]}, 32'h0057_3412, "push22");
    exec(ow(op_indirect_call, 3'h0, 7'h00, 1'b0), 22'h00_0200, 2'b11, 22'h00_1234, 4'h3);
    chk(32'(u_stack_model.pushes), 32'h0000_0008, "push count");
  endtask

  task automatic t_skips();
    apb(1'b1, OFF_FLAGS, 32'h0000_00A5);
    apb(1'b1, OFF_OPERANDS, 32'h0080_5A5A);
    sk(op_compare_skip_equal, 3'h0, 1'b1, 22'h00_0013, 4'h3);
    sk(op_compare_skip_equal, 3'h0, 1'b0, 22'h00_0012, 4'h2);
    apb(1'b1, OFF_OPERANDS, 32'h0080_5B5A);
    sk(op_compare_skip_equal, 3'h0, 1'b1, 22'h00_0011, 4'h1);
    sk(op_skip_reg_bit_clear, 3'h0, 1'b0, 22'h00_0011, 4'h1);
    sk(op_skip_reg_bit_clear, 3'h2, 1'b0, 22'h00_0012, 4'h2);
    sk(op_skip_reg_bit_set, 3'h0, 1'b1, 22'h00_0013, 4'h3);
    sk(op_skip_reg_bit_set, 3'h2, 1'b1, 22'h00_0011, 4'h1);
    sk(op_skip_io_bit_clear, 3'h7, 1'b0, 22'h00_0011, 4'h2);
    sk(op_skip_io_bit_clear, 3'h0, 1'b0, 22'h00_0012, 4'h3);
    sk(op_skip_io_bit_set, 3'h7, 1'b1, 22'h00_0013, 4'h4);
    apb(1'b0, OFF_FLAGS, 32'h0000_0000);
    chk(rd, 32'h0000_00A5, "flags kept");
  endtask

  // every branch opcode against flag patterns that split each condition
  task automatic t_branches();
    logic [7:0] pat [8] = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h55, 8'hAA, 8'h20, 8'h40};
    logic [21:0] tgt;
    logic [6:0] k;
    for (int o = 7; o < 27; o++) begin
      for (int i = 0; i < 8; i++) begin
        k = i[0] ? 7'h3F : 7'h40;
        tgt = i[0] ? 22'h00_0140 : 22'h00_00C1;
        apb(1'b1, OFF_FLAGS, {24'h00_0000, pat[i]});
        if (cond(o, pat[i], 3'(i))) begin
          exec(ow(5'(o), 3'(i), k, 1'b0), 22'h00_0100, 2'b01, tgt, 4'h2);
        end else begin
          exec(ow(5'(o), 3'(i), k, 1'b0), 22'h00_0100, 2'b01, 22'h00_0101, 4'h1);
        end
        apb(1'b0, OFF_FLAGS, 32'h0000_0000);
        chk(rd, {24'h00_0000, pat[i]}, "flags kept");
      end
    end
  endtask
  // the table walk above also

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_calls();
    t_skips();
    t_branches();
    end_sim();
  end
endmodule // test_branch_call_skip_control
